// file: enc_trig_pkg.sv
// shared constants for the encoder trigger generator
package enc_trig_pkg;
  // ----------------------------------------
  // clock and time
  // ----------------------------------------
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned SEC_NS      = 1000000000;
  localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_NS;
  localparam int unsigned FILT_MAX_NS = 150;
  localparam int unsigned FILT_CYC_W  = 4;
  localparam int unsigned MAX_IV_S    = 60;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_SRC     = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_DIV     = 8'h08;
  localparam logic [7:0] OFS_SKIP    = 8'h0c;
  localparam logic [7:0] OFS_FILT    = 8'h10;
  localparam logic [7:0] OFS_WIDTH   = 8'h14;
  localparam logic [7:0] OFS_MAXIV   = 8'h18;
  localparam logic [7:0] OFS_BACK    = 8'h1c;
  localparam logic [7:0] OFS_STAT    = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned SRC_B_LSB  = 8;
  localparam int unsigned CTRL_METH  = 0;
  localparam int unsigned CTRL_MODE  = 4;
  localparam int unsigned CTRL_DIR   = 8;
  localparam int unsigned CTRL_AVG   = 12;
  localparam int unsigned CTRL_BEGIN = 16;
  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [5:0]  SRC_OFF    = 6'h00;
  localparam logic [5:0]  SRC_TTL1   = 6'h17;
  localparam logic [5:0]  SRC_OPT    = 6'h18;
  localparam logic [5:0]  SRC_TTL4   = 6'h21;
  localparam logic        METH_FRAC  = 1'h0;
  localparam logic        METH_SKIP  = 1'h1;
  localparam logic [2:0]  MODE_ADV   = 3'h1;
  localparam logic [2:0]  MODE_RET   = 3'h2;
  localparam logic [2:0]  MODE_MOT   = 3'h5;
  localparam logic        DIR_FWD    = 1'h0;
  localparam logic [2:0]  AVG_NONE   = 3'h0;
  localparam logic [2:0]  AVG_MAX    = 3'h5;
  localparam logic [31:0] DIV_RST    = 32'h0001_0000;
  localparam logic [32:0] FRAC_STEP  = 33'h0_0001_0000;
  localparam logic [15:0] SKIP_RST   = 16'h0000;
  localparam logic [7:0]  FILT_RST   = 8'h00;
  localparam logic [11:0] WIDTH_RST  = 12'h064;
  localparam logic [5:0]  MAXIV_RST  = 6'h00;
endpackage

// file: phase_filter.sv
// synchroniser and stability filter for the encoder line inputs
module phase_filter
  import enc_trig_pkg::*;
#(
  parameter int unsigned W = 3
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // raw pins and filtered levels
  input  wire logic [W-1:0]          raw,
  input  wire logic [FILT_CYC_W-1:0] lim,
  output logic      [W-1:0]          q
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0]                 s1;
    logic [W-1:0]                 s2;
    logic [W-1:0]                 q;
    logic [W-1:0][FILT_CYC_W-1:0] cnt;
  } flt_t;

  flt_t st_r;
  flt_t st_nxt;

  if (W == 0) begin : g_chk
    $error("phase_filter needs at least one input");
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    for (int i = 0; i < W; i++) begin
      // a level must stand lim+1 cycles past the sync before it is taken
      if (st_r.s2[i] == st_r.q[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] >= lim) begin
        st_nxt.q[i]   = st_r.s2[i]; // R11
        st_nxt.cnt[i] = '0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_filter_hold : assert property (@(posedge clk) disable iff (rst) // R11
    (st_r.q != $past(st_r.q)) |-> ($past(st_r.cnt[0]) >= $past(lim) || $past(st_r.q[0]) == st_r.q[0]))
    else $error("filtered level changed before the hold time");
endmodule // phase_filter

// file: enc_trig.sv
// encoder to line trigger generator
// Contract
// R1 - phase sources selectable, off by default
// R2 - method: fractional division or edge skipping
// R3 - fractional: rate edges times 65536 over divisor
// R4 - skipping: programmed edges pass between triggers
// R5 - travel mode: advance, retreat or motion
// R6 - advance mode suppresses images until backlash zero
// R7 - retreat mode suppresses images until backlash zero
// R8 - motion mode: image at every increment
// R9 - backlash counts up on reverse pulses
// R10 - backlash counts down on selected direction
// R11 - input level must stay stable filter time
// R12 - trigger pulse stretched to programmed width
// R13 - interval averaging over 2 to 32 pulses
// R14 - averaging only in non-integer fractional division
// R15 - max interval ignored for integer divisor
// R16 - max interval zero: input period alone
// R17 - max interval nonzero limits output period
// R18 - object direction sets positive direction
// R19 - quadrature decode gives edge and direction
//
// Local design decisions: the strobed register port and the address map.
module enc_trig
  import enc_trig_pkg::*;
#(
  parameter int unsigned CYC_SEC = CYC_PER_SEC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // line inputs
  input  wire logic        TTL1_IN,
  input  wire logic        OPT_IN,
  input  wire logic        TTL4_IN,
  // trigger outputs
  output logic             TRIG_OUT,
  output logic             IMAGE_OUT
);
  if (CYC_SEC == 0 || CYC_SEC > 32'h0400_0000) begin : g_chk
    $error("CYC_SEC out of range");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [5:0]  sa;
    logic [5:0]  sb;
    logic        meth;
    logic [2:0]  mode;
    logic        odir;
    logic [2:0]  avgd;
    logic [31:0] div;
    logic [15:0] skip;
    logic [7:0]  filt;
    logic [11:0] width;
    logic [5:0]  maxs;
    logic [31:0] back;
    logic [1:0]  ab;
    logic [32:0] acc;
    logic [15:0] scnt;
    logic [31:0] iv;
    logic [31:0] avg;
    logic [31:0] gap;
    logic [11:0] wcnt;
    logic        trig;
    logic        img;
    logic        ok;
    logic        up;
    logic [31:0] rdata;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic sel_pin(input logic [5:0] code, input logic [2:0] pins);
    case (code)
      SRC_TTL1: sel_pin = pins[0];
      SRC_OPT:  sel_pin = pins[1];
      SRC_TTL4: sel_pin = pins[2];
      default:  sel_pin = 1'b0;
    endcase
  endfunction

  // rounds a time in ns up to whole clock cycles
  function automatic logic [11:0] ns_to_cyc(input logic [11:0] ns);
    logic [12:0] t;
    t = 13'(ns) + 13'(CLK_NS - 1);
    ns_to_cyc = 12'(t / 13'(CLK_NS));
  endfunction

  // ----------------------------------------
  // inputs
  // ----------------------------------------
  logic [2:0]  pins_f;
  logic [FILT_CYC_W-1:0] flim;

  assign flim = FILT_CYC_W'(ns_to_cyc({4'h0, st_r.filt}));

  phase_filter #(
    .W (3)
  ) u_filt (
    .clk (CLK),
    .rst (RST),
    .raw ({TTL4_IN, OPT_IN, TTL1_IN}),
    .lim (flim),
    .q   (pins_f)
  );

  logic        pa;
  logic        pb;
  logic [1:0]  ab_now;
  logic        step;
  logic        cw;
  logic        pos;
  logic        sel_dir;
  logic        dirmode;

  assign pa      = sel_pin(st_r.sa, pins_f); // R1
  assign pb      = sel_pin(st_r.sb, pins_f); // R1
  assign ab_now  = {pa, pb};
  assign step    = ^(ab_now ^ st_r.ab); // R19
  assign cw      = st_r.ab[1] ^ pb; // R19
  assign pos     = cw ^ st_r.odir; // R18
  assign dirmode = (st_r.mode == MODE_ADV) || (st_r.mode == MODE_RET); // R5
  assign sel_dir = (st_r.mode == MODE_RET) ? !pos : pos; // R6 R7

  // ----------------------------------------
  // trigger timing
  // ----------------------------------------
  logic        int_mult;
  logic        pend;
  logic [63:0] prod;
  logic [31:0] space;
  logic [31:0] lim_cyc;
  logic [31:0] space_lim;
  logic        fire;
  logic        skip_hit;
  logic [11:0] wcyc;

  assign int_mult  = (st_r.div[15:0] == 16'h0000);
  assign pend      = (st_r.acc >= {1'b0, st_r.div});
  assign prod      = 64'(st_r.avg) * 64'(st_r.div);
  assign space     = (prod[63:48] != 16'h0000) ? 32'hffff_ffff : prod[47:16]; // R3
  assign lim_cyc   = 32'(st_r.maxs) * 32'(CYC_SEC);
  assign space_lim = (st_r.maxs != 6'h00 && lim_cyc < space) ? lim_cyc : space; // R16 R17
  assign skip_hit  = step && (st_r.scnt == st_r.skip); // R4
  assign wcyc      = (ns_to_cyc(st_r.width) == 12'h000) ? 12'h001 : ns_to_cyc(st_r.width);

  always_comb begin
    if (st_r.meth == METH_SKIP) begin
      fire = skip_hit; // R2
    end else if (int_mult) begin
      fire = pend; // R15
    end else begin
      fire = pend && (st_r.gap >= space_lim); // R14
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic        wr_begin;
  logic        img_ok;
  logic [32:0] dlt;

  assign wr_begin = REG_WR && (REG_ADDR == OFS_CTRL) && REG_WDATA[CTRL_BEGIN];
  // a reverse step masks its own image, not only the ones after it
  assign img_ok   = !dirmode || (st_r.ok && (!step || sel_dir)); // R6 R7 R8

  always_comb begin
    st_nxt    = st_r;
    st_nxt.ab = ab_now;
    dlt       = 33'(st_r.iv) - 33'(st_r.avg);
    // register writes
    if (REG_WR) begin
      case (REG_ADDR)
        OFS_SRC: begin
          st_nxt.sa = REG_WDATA[5:0];
          st_nxt.sb = REG_WDATA[SRC_B_LSB +: 6];
        end
        OFS_CTRL: begin
          st_nxt.meth = REG_WDATA[CTRL_METH];
          st_nxt.mode = REG_WDATA[CTRL_MODE +: 3];
          st_nxt.odir = REG_WDATA[CTRL_DIR];
          st_nxt.avgd = (REG_WDATA[CTRL_AVG +: 3] > AVG_MAX) ? AVG_MAX : REG_WDATA[CTRL_AVG +: 3];
        end
        OFS_DIV:   st_nxt.div   = (REG_WDATA == 32'h0) ? 32'h1 : REG_WDATA;
        OFS_SKIP:  st_nxt.skip  = REG_WDATA[15:0];
        OFS_FILT:  st_nxt.filt  = (REG_WDATA[7:0] > 8'(FILT_MAX_NS)) ? 8'(FILT_MAX_NS) : REG_WDATA[7:0];
        OFS_WIDTH: st_nxt.width = REG_WDATA[11:0];
        OFS_MAXIV: st_nxt.maxs  = (REG_WDATA[5:0] > 6'(MAX_IV_S)) ? 6'(MAX_IV_S) : REG_WDATA[5:0];
        default: begin
        end
      endcase
    end
    // interval measurement and averaging
    st_nxt.gap = (st_r.gap == 32'hffff_ffff) ? st_r.gap : st_r.gap + 32'h1;
    st_nxt.iv  = (st_r.iv == 32'hffff_ffff) ? st_r.iv : st_r.iv + 32'h1;
    if (step) begin
      st_nxt.iv = 32'h1;
      if (st_r.avgd == AVG_NONE || int_mult || st_r.meth == METH_SKIP) begin
        st_nxt.avg = st_r.iv; // R14
      end else begin
        st_nxt.avg = 32'(33'(st_r.avg) + 33'($signed(dlt) >>> st_r.avgd)); // R13
      end
    end
    // backlash tracking, image permitted only at zero
    if (step && dirmode) begin
      st_nxt.up = pos;
      if (!sel_dir) begin
        if (st_r.back != 32'hffff_ffff) begin
          st_nxt.back = st_r.back + 32'h1; // R9
        end
        st_nxt.ok = 1'b0;
      end else if (st_r.back != 32'h0) begin
        st_nxt.back = st_r.back - 32'h1; // R10
        st_nxt.ok   = 1'b0;
      end else begin
        st_nxt.ok = 1'b1; // R6 R7
      end
    end
    if (wr_begin) begin
      st_nxt.back = 32'h0;
      st_nxt.ok   = 1'b1;
    end
    // edge skipping counter
    if (step) begin
      st_nxt.scnt = skip_hit ? 16'h0000 : st_r.scnt + 16'h1; // R4
    end
    // fractional accumulator
    st_nxt.acc = st_r.acc;
    if (step && !st_r.acc[32]) begin
      st_nxt.acc = st_r.acc + FRAC_STEP; // R3
    end
    if (st_r.meth == METH_SKIP || wr_begin) begin
      st_nxt.acc = '0;
    end else if (fire) begin
      st_nxt.acc = st_nxt.acc - {1'b0, st_r.div}; // R3
    end
    // pulse stretch; a new trigger restarts the width
    if (fire) begin
      st_nxt.gap  = 32'h0;
      st_nxt.trig = 1'b1;
      st_nxt.img  = img_ok; // R6 R7 R8
      st_nxt.wcnt = wcyc - 12'h1; // R12
    end else if (st_r.wcnt != 12'h000) begin
      st_nxt.wcnt = st_r.wcnt - 12'h1; // R12
    end else begin
      st_nxt.trig = 1'b0;
      st_nxt.img  = 1'b0;
    end
    // register reads
    st_nxt.rdata = 32'h0;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_SRC:   st_nxt.rdata = {18'h0, st_r.sb, 2'h0, st_r.sa};
        OFS_CTRL:  st_nxt.rdata = {17'h0, st_r.avgd, 3'h0, st_r.odir, 1'h0, st_r.mode, 3'h0,
                                   st_r.meth};
        OFS_DIV:   st_nxt.rdata = st_r.div;
        OFS_SKIP:  st_nxt.rdata = {16'h0, st_r.skip};
        OFS_FILT:  st_nxt.rdata = {24'h0, st_r.filt};
        OFS_WIDTH: st_nxt.rdata = {20'h0, st_r.width};
        OFS_MAXIV: st_nxt.rdata = {26'h0, st_r.maxs};
        OFS_BACK:  st_nxt.rdata = st_r.back; // R9
        OFS_STAT:  st_nxt.rdata = {26'h0, st_r.ab, st_r.up, st_r.ok, st_r.img, st_r.trig};
        default:   st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r       <= '0;
      st_r.sa    <= SRC_OFF;
      st_r.sb    <= SRC_OFF;
      st_r.meth  <= METH_FRAC;
      st_r.mode  <= MODE_MOT;
      st_r.odir  <= DIR_FWD;
      st_r.avgd  <= AVG_NONE;
      st_r.div   <= DIV_RST;
      st_r.skip  <= SKIP_RST;
      st_r.filt  <= FILT_RST;
      st_r.width <= WIDTH_RST;
      st_r.maxs  <= MAXIV_RST;
      st_r.ok    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign TRIG_OUT  = st_r.trig;
  assign IMAGE_OUT = st_r.img;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_fire;
    fire;
  endsequence

  sequence s_pulse_start;
    TRIG_OUT && (st_r.wcnt == $past(wcyc) - 12'h1);
  endsequence

  property p_fire_pulse;
    s_fire |=> s_pulse_start;
  endproperty

  a_pulse_start : assert property (p_fire_pulse) // R12
    else $error("trigger did not start with full width");

  a_pulse_min : assert property ($rose(TRIG_OUT) && wcyc == 12'h2 && !fire |=> TRIG_OUT) // R12
    else $error("trigger shorter than two cycles");

  a_skip_fire : assert property ((st_r.meth == METH_SKIP) && step && st_r.scnt == st_r.skip |=> TRIG_OUT) // R4
    else $error("edge skip missed a trigger");

  a_skip_quiet : assert property ((st_r.meth == METH_SKIP) && st_r.scnt != st_r.skip |-> !fire) // R2
    else $error("edge skip fired early");

  a_backlash_up : assert property (dirmode && step && !sel_dir && !wr_begin
    && st_r.back != 32'hffff_ffff |=> st_r.back == $past(st_r.back) + 32'h1) // R9
    else $error("backlash did not count up");

  a_backlash_down : assert property (dirmode && step && sel_dir && !wr_begin
    && st_r.back != 32'h0 |=> st_r.back == $past(st_r.back) - 32'h1) // R10
    else $error("backlash did not count down");

  a_image_mask : assert property (fire && dirmode && !st_r.ok |=> TRIG_OUT && !IMAGE_OUT) // R6
    else $error("image passed while masked");

  a_reverse_mask : assert property (fire && dirmode && step && !sel_dir |=> !IMAGE_OUT) // R7
    else $error("image passed on a reverse step");

  a_motion_image : assert property (fire && st_r.mode == MODE_MOT |=> IMAGE_OUT) // R8
    else $error("motion mode dropped an image");

  a_src_off : assert property (st_r.sa == SRC_OFF |-> !pa) // R1
    else $error("disconnected phase not low");

  a_int_div : assert property ((st_r.meth == METH_FRAC) && int_mult && pend |-> fire) // R15
    else $error("integer divisor held a trigger");

  a_read_back : assert property (REG_RD && REG_ADDR == OFS_BACK |=> REG_RDATA == $past(st_r.back)) // R9
    else $error("backlash read wrong");
endmodule // enc_trig

// file: enc_model.sv
// quadrature encoder model driving the camera line inputs
module enc_model (
  // clock
  input  wire logic       clk,
  // pins: bit0 first ttl, bit1 optical, bit2 fourth ttl
  output logic      [2:0] line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ab    = 2'h0;
  logic       noise = 1'b0;
  int         sa    = 0;
  int         sb    = 2;
  // ----------------------------------------
  // pins
  // ----------------------------------------
  // unrouted pins toggle each cycle so a wrong select shows as steps
  always @(posedge clk) begin
    noise <= ~noise;
  end
  always_comb begin
    line     = {3{noise}};
    line[sa] = ab[1];
    line[sb] = ab[0];
  end
  // ----------------------------------------
  // motion
  // ----------------------------------------
  // one gray step, forward runs 00 01 11 10
  task automatic step(input logic fwd, input int gap);
    logic [1:0] n;
    n = {ab[1], ^ab} + (fwd ? 2'h1 : 2'h3);
    @(posedge clk);
    ab <= {n[1], ^n};
    repeat (gap) @(posedge clk);
  endtask
  // short bounce on phase a only
  task automatic glitch(input int len);
    @(posedge clk);
    ab[1] <= ~ab[1];
    repeat (len) @(posedge clk);
    ab[1] <= ~ab[1];
    repeat (20) @(posedge clk);
  endtask
endmodule // enc_model

// file: test_enc_trig.sv
// self-checking bench for the encoder trigger generator
module test_enc_trig;
  import enc_trig_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic        TRIG_OUT;
  logic        IMAGE_OUT;
  logic [2:0]  line;
  logic        trig_d = 1'b0;
  logic        img_d = 1'b0;
  logic        sel;
  logic [2:0]  md;
  int          fail_count = 0;
  int          comparisons = 0;
  int          trig_n = 0;
  int          img_n = 0;
  int          hi = 0;
  int          wid = 0;
  int          t0;
  int          i0;
  logic [7:0]  ra[9] = '{OFS_SRC, OFS_CTRL, OFS_DIV, OFS_SKIP, OFS_FILT, OFS_WIDTH,
                         OFS_MAXIV, OFS_BACK, 8'h24};
  logic [31:0] rv[9] = '{32'h0, 32'h50, 32'h1_0000, 32'h0, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0};
  logic [5:0]  sc[3] = '{SRC_TTL1, SRC_OPT, SRC_TTL4};
  int          wns[3] = '{10, 100, 2550};
  int          wcy[3] = '{1, 2, 51};

  enc_trig #(.CYC_SEC(100)) uut (
    .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .TTL1_IN(line[0]), .OPT_IN(line[1]),
    .TTL4_IN(line[2]), .TRIG_OUT(TRIG_OUT), .IMAGE_OUT(IMAGE_OUT)
  );
  enc_model enc (.clk(CLK), .line(line));

  // ----------------------------------------
  // clock, monitor, helpers
  // ----------------------------------------
  initial begin
    forever #25 CLK = ~CLK;
  end
  // rising edges counted, so fires closer than the width merge into one
  always @(posedge CLK) begin
    trig_d <= TRIG_OUT;
    img_d <= IMAGE_OUT;
    if (TRIG_OUT === 1'b1 && trig_d !== 1'b1) trig_n <= trig_n + 1;
    if (IMAGE_OUT === 1'b1 && img_d !== 1'b1) img_n <= img_n + 1;
    hi <= (TRIG_OUT === 1'b1) ? hi + 1 : 0;
    if (TRIG_OUT !== 1'b1 && trig_d === 1'b1) wid <= hi;
  end
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    check(REG_RDATA, e);
    @(posedge CLK);
  endtask
  function automatic logic [31:0] cw(logic m, logic [2:0] mo, logic d, logic [2:0] av);
    return {17'h0, av, 3'h0, d, 1'b0, mo, 3'h0, m};
  endfunction
  task automatic steps(input logic fwd, input int n);
    repeat (n) enc.step(fwd, 14);
    repeat (12) @(posedge CLK);
  endtask
  task automatic mark();
    t0 = trig_n;
    i0 = img_n;
  endtask

  // ----------------------------------------
  // watchdog and tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    wr(OFS_BACK, 32'h5);
    rd_chk(OFS_BACK, 32'h0);
    wr(OFS_DIV, 32'h0);
    rd_chk(OFS_DIV, 32'h1);
    wr(OFS_FILT, 32'd200);
    rd_chk(OFS_FILT, 32'd150);
    wr(OFS_MAXIV, 32'd62);
    rd_chk(OFS_MAXIV, 32'd60);
    wr(OFS_MAXIV, 32'd0);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, cw(METH_SKIP, MODE_MOT, DIR_FWD, 3'(i)));
      rd_chk(OFS_CTRL, cw(METH_SKIP, MODE_MOT, DIR_FWD, (i > 5) ? AVG_MAX : 3'(i)));
    end
    wr(OFS_CTRL, cw(METH_SKIP, MODE_MOT, DIR_FWD, AVG_NONE));
    wr(OFS_FILT, 32'd0);
    // three source pairings in rotation, then both phases off
    for (int i = 0; i < 4; i++) begin
      if (i < 3) begin
        enc.sa <= i;
        enc.sb <= (i + 1) % 3;
      end
      wr(OFS_SRC, (i < 3) ? {18'h0, sc[(i + 1) % 3], 2'h0, sc[i]} : 32'h0);
      repeat (10) @(posedge CLK);
      mark();
      steps(1'b1, 4);
      check(32'(trig_n - t0), (i < 3) ? 32'd4 : 32'd0);
    end
    wr(OFS_SRC, {18'h0, SRC_TTL4, 2'h0, SRC_TTL1});
    enc.sa <= 0;
    enc.sb <= 2;
    repeat (10) @(posedge CLK);
    wr(OFS_SKIP, 32'd2);
    mark();
    steps(1'b0, 9);
    check(32'(trig_n - t0), 32'd3);
    wr(OFS_SKIP, 32'd0);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_WIDTH, 32'(wns[i]));
      enc.step(1'b1, 60);
      check(32'(wid), 32'(wcy[i]));
    end
    wr(OFS_WIDTH, 32'd100);
    // integer divisor ignores the max interval
    wr(OFS_DIV, 32'h3_0000);
    wr(OFS_MAXIV, 32'd1);
    wr(OFS_CTRL, cw(METH_FRAC, MODE_MOT, DIR_FWD, AVG_NONE) | 32'h1_0000);
    mark();
    steps(1'b1, 9);
    check(32'(trig_n - t0), 32'd3);
    wr(OFS_MAXIV, 32'd0);
    wr(OFS_DIV, 32'h1_8000);
    wr(OFS_CTRL, cw(METH_FRAC, MODE_MOT, DIR_FWD, 3'h1) | 32'h1_0000);
    mark();
    steps(1'b1, 12);
    check(32'(trig_n - t0 >= 4 && trig_n - t0 <= 8), 32'd1);
    // backlash: advance, retreat, advance with reversed object
    for (int k = 0; k < 3; k++) begin
      md = (k == 1) ? MODE_RET : MODE_ADV;
      sel = (md == MODE_ADV) ^ (k == 2);
      wr(OFS_CTRL, cw(METH_SKIP, md, k == 2, AVG_NONE) | 32'h1_0000);
      steps(sel, 2);
      mark();
      steps(~sel, 3);
      rd_chk(OFS_BACK, 32'd3);
      check(32'(trig_n - t0), 32'd3);
      check(32'(img_n - i0), 32'd0);
      steps(sel, 3);
      rd_chk(OFS_BACK, 32'd0);
      check(32'(img_n - i0), 32'd0);
      steps(sel, 2);
      check(32'(img_n > i0), 32'd1);
    end
    wr(OFS_CTRL, cw(METH_SKIP, MODE_MOT, DIR_FWD, AVG_NONE));
    mark();
    steps(1'b1, 2);
    steps(1'b0, 3);
    check(32'(img_n - i0), 32'd5);
    wr(OFS_FILT, 32'd150);
    mark();
    enc.glitch(3);
    check(32'(trig_n - t0), 32'd0);
    steps(1'b1, 1);
    check(32'(trig_n - t0), 32'd1);
    finish_test();
  end
endmodule // test_enc_trig
